// File: core/hsr_status.sv
// Status byte, event registers, masks and break detection for the remote host
// Overview of operation
// - Events set sticky bits until queried
// - Enable masks each event register into summary
// - Enabled status byte bit raises service request
// - Power-on clears all flags and masks
// - Status byte: port summary 0, ESB 5, MSS 6
// - MSS is OR of status byte AND mask
// - Service mask bit 6 ignores writes, reads 0
// - Five sticky standard flags, cleared by read/clear
// - Indexed query clears only that bit
// - Standard flag positions 0,1,3,4,5; others zero
// - Input buffer overflow sets input overflow flag
// - Command queue overflow sets device error flag
// - Execution and parser errors set their flags
// - ESB is OR of standard flags AND mask
// - Four sticky port flags, bits 4-7 zero
// - Port break sets port flag, requests service only via port and service masks
// - Port summary is OR of port flags AND mask
// - Set form of query-only command records code 4
// - Clear-status clears standard and port flags
`timescale 1ns/1ps
module hsr_status import hsr_pkg::*; #(
   parameter int BREAK_CYCLES = BREAK_CYCLES_DEF
) (
   input wire logic clock, // 250 MHz clock
   input wire logic rstn, // Async reset, power-on
   input wire hsr_cmd_s cmd, // Decoded remote command
   input wire hsr_evt_s evt, // Event pulses
   input wire logic [NUM_PORTS-1:0] port_rx, // Optical port receive lines
   output logic rsp_valid, // Query answer strobe
   output logic [7:0] rsp_data, // Query answer
   output logic rqs // Request service
);
   localparam logic [BRK_W-1:0] BRK_LIM = BRK_W'(BREAK_CYCLES);

   hsr_state_s s_q;
   hsr_state_s s_d;
   logic [NUM_PORTS-1:0] brk_hit;
   logic [7:0] stb_now;

   // Bits a query returns and therefore clears
   function automatic logic [7:0] sel_mask(input logic idx_en, input logic [2:0] idx);
      logic [7:0] m;
      m = 8'hFF;
      if (idx_en) begin
         m = 8'h01 << idx;
      end
      return m;
   endfunction

   // Whole-byte or single-bit write
   function automatic logic [7:0] apply_set(input logic [7:0] old, input hsr_cmd_s c);
      logic [7:0] r;
      r = c.data;
      if (c.idx_en) begin
         r = old;
         r[c.idx] = c.data[0];
      end
      return r;
   endfunction

   // Query answer: whole byte or one bit
   function automatic logic [7:0] answer(input logic [7:0] v, input hsr_cmd_s c);
      logic [7:0] r;
      r = v;
      if (c.idx_en) begin
         r = {7'h00, v[c.idx]};
      end
      return r;
   endfunction

   function automatic logic [7:0] status_byte(input hsr_state_s s);
      logic [7:0] b;
      b = 8'h00;
      b[STB_PORT_BIT] = |(s.port_flags & s.port_mask);
      b[STB_ESB_BIT] = |(s.std_flags & s.std_mask);
      b[STB_MSS_BIT] = |(b & s.srq_mask);
      return b;
   endfunction

   generate
      for (genvar g = 0; g < NUM_PORTS; g++) begin : g_brk
         // One hit per break, when the space outlasts a frame
         assign brk_hit[g] = !port_rx[g] && (s_q.brk_cnt[g] == BRK_LIM)
                             && !s_q.brk_seen[g];
      end
   endgenerate

   assign stb_now = status_byte(s_q);

   always_comb begin
      logic [7:0] ev_std;
      logic [7:0] ev_port;
      logic [7:0] next_stb;
      ev_std = 8'h00;
      ev_port = 8'h00;
      next_stb = 8'h00;
      s_d = s_q;
      s_d.rsp_valid = 1'b0;
      s_d.rsp_data = 8'h00;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (port_rx[i]) begin
            s_d.brk_cnt[i] = '0;
            s_d.brk_seen[i] = 1'b0;
         end else if (s_q.brk_cnt[i] != BRK_LIM) begin
            s_d.brk_cnt[i] = s_q.brk_cnt[i] + BRK_W'(1);
         end else if (brk_hit[i]) begin
            s_d.brk_seen[i] = 1'b1;
         end
      end
      case (cmd.op)
         OP_STB_Q: begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = answer(stb_now, cmd);
         end
         OP_SRQ_SET: begin
            s_d.srq_mask = apply_set(s_q.srq_mask, cmd) & SRQ_WR_MASK;
         end
         OP_SRQ_Q: begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = answer(s_q.srq_mask, cmd);
         end
         OP_STD_Q: begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = answer(s_q.std_flags, cmd);
            s_d.std_flags = s_q.std_flags & ~sel_mask(cmd.idx_en, cmd.idx);
         end
         OP_STDM_SET: begin
            s_d.std_mask = apply_set(s_q.std_mask, cmd);
         end
         OP_STDM_Q: begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = answer(s_q.std_mask, cmd);
         end
         OP_PEF_Q: begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = answer(s_q.port_flags, cmd);
            s_d.port_flags = s_q.port_flags & ~sel_mask(cmd.idx_en, cmd.idx);
         end
         OP_PEM_SET: begin
            s_d.port_mask = apply_set(s_q.port_mask, cmd);
         end
         OP_PEM_Q: begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = answer(s_q.port_mask, cmd);
         end
         OP_CLS: begin
            s_d.std_flags = REG_RST;
            s_d.port_flags = REG_RST;
         end
         OP_OPC: begin
            ev_std[EF_OPC_BIT] = 1'b1;
         end
         OP_IDN_SET: begin
            ev_std[EF_CME_BIT] = 1'b1;
            s_d.cme_code = CME_ILLEGAL_SET;
         end
         OP_CERR_Q: begin
            s_d.rsp_valid = 1'b1;
            s_d.rsp_data = s_q.cme_code;
            s_d.cme_code = CME_NONE;
         end
         default: begin
         end
      endcase
      if (evt.parse_err) begin
         s_d.cme_code = evt.parse_code;
      end
      ev_std[EF_OVF_BIT] = evt.in_ovf;
      ev_std[EF_DDE_BIT] = evt.queue_ovf;
      ev_std[EF_EXE_BIT] = evt.exec_err;
      ev_std[EF_CME_BIT] = ev_std[EF_CME_BIT] | evt.parse_err;
      ev_port[NUM_PORTS-1:0] = brk_hit;
      // New events win over a clear in the same cycle
      s_d.std_flags = (s_d.std_flags | ev_std) & EF_DEF_MASK;
      s_d.port_flags = (s_d.port_flags | ev_port) & PF_DEF_MASK;
      // Request service follows the byte as it will stand after this edge
      next_stb = status_byte(s_d);
      s_d.rqs = next_stb[STB_MSS_BIT];
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign rsp_valid = s_q.rsp_valid;
   assign rsp_data = s_q.rsp_data;
   assign rqs = s_q.rqs;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_clear_req;
      cmd.op == OP_CLS && !evt.in_ovf && !evt.queue_ovf && !evt.exec_err && !evt.parse_err;
   endsequence
   sequence s_flags_empty;
      s_q.std_flags == 8'h00 && s_q.port_flags == 8'h00;
   endsequence
   sequence s_std_keep;
      cmd.op != OP_STD_Q && cmd.op != OP_CLS;
   endsequence
   sequence s_port_keep;
      cmd.op != OP_PEF_Q && cmd.op != OP_CLS;
   endsequence

   rqs_tracks_mss_a: assert property (rqs == |(stb_now & s_q.srq_mask))
      else $error("request service differs from masked status byte");
   srq_bit6_zero_a: assert property (!s_q.srq_mask[6]
      && stb_now[7:1] == {1'b0, stb_now[6:5], 4'h0})
      else $error("service mask bit 6 or status byte reserved bits set");
   reserved_zero_a: assert property ((s_q.std_flags & 8'hC4) == 8'h00
      && s_q.port_flags[7:4] == 4'h0)
      else $error("reserved event flag bit set");
   ovf_sticky_a: assert property (evt.in_ovf |=> s_q.std_flags[EF_OVF_BIT]
      ##1 (s_q.std_flags[EF_OVF_BIT] || $past(cmd.op) == OP_STD_Q
      || $past(cmd.op) == OP_CLS))
      else $error("input overflow flag not held");
   err_flags_a: assert property ((evt.queue_ovf && evt.exec_err)
      |=> s_q.std_flags[EF_DDE_BIT] && s_q.std_flags[EF_EXE_BIT])
      else $error("queue or execution error flag not set");
   cls_clears_a: assert property (s_clear_req and brk_hit == 4'h0 |=> s_flags_empty)
      else $error("clear status left flags set");
   bit_query_a: assert property ((cmd.op == OP_STD_Q && cmd.idx_en && !evt.in_ovf
      && !evt.queue_ovf && !evt.exec_err && !evt.parse_err)
      |=> s_q.std_flags == ($past(s_q.std_flags) & ~(8'h01 << $past(cmd.idx))))
      else $error("indexed query cleared wrong bits");
   illegal_set_a: assert property (cmd.op == OP_IDN_SET && !evt.parse_err
      |=> s_q.cme_code == CME_ILLEGAL_SET && s_q.std_flags[EF_CME_BIT])
      else $error("illegal set not recorded");
   port_break_a: assert property (brk_hit[0] |=> s_q.port_flags[0] && s_q.brk_seen[0])
      else $error("port break not flagged");
   query_answer_a: assert property (cmd.op == OP_STB_Q && !cmd.idx_en
      |=> rsp_valid && rsp_data == $past(stb_now))
      else $error("status byte answer wrong");
   rsp_idle_a: assert property (cmd.op == OP_NONE |=> !rsp_valid && rsp_data == 8'h00)
      else $error("answer given without a query");
   srq_write_a: assert property (cmd.op == OP_SRQ_SET && !cmd.idx_en
      |=> s_q.srq_mask == ($past(cmd.data) & SRQ_WR_MASK))
      else $error("service mask write wrong");
   opc_sets_a: assert property (cmd.op == OP_OPC |=> s_q.std_flags[EF_OPC_BIT])
      else $error("operation complete flag not set");
   parse_err_a: assert property (evt.parse_err
      |=> s_q.cme_code == $past(evt.parse_code) && s_q.std_flags[EF_CME_BIT])
      else $error("parser error not recorded");
   std_sticky_a: assert property (s_q.std_flags[EF_DDE_BIT] and s_std_keep
      |=> s_q.std_flags[EF_DDE_BIT])
      else $error("standard flag dropped without read or clear");
   port_sticky_a: assert property (s_q.port_flags[0] and s_port_keep
      |=> s_q.port_flags[0])
      else $error("port flag dropped without read or clear");
   break_once_a: assert property (s_q.brk_seen[0] && !port_rx[0] |-> !brk_hit[0])
      else $error("second hit within one break");
endmodule

// File: core/hsr_pkg.sv
// Shared constants and types for the hierarchical status reporting block
package hsr_pkg;
   // Status summary byte layout
   localparam int STB_PORT_BIT = 0;
   localparam int STB_ESB_BIT = 5;
   localparam int STB_MSS_BIT = 6;
   localparam logic [7:0] SRQ_WR_MASK = 8'hBF;
   // Standard event flag layout
   localparam int EF_OPC_BIT = 0;
   localparam int EF_OVF_BIT = 1;
   localparam int EF_DDE_BIT = 3;
   localparam int EF_EXE_BIT = 4;
   localparam int EF_CME_BIT = 5;
   localparam logic [7:0] EF_DEF_MASK = 8'h3B;
   // Port event flag layout
   localparam int NUM_PORTS = 4;
   localparam logic [7:0] PF_DEF_MASK = 8'h0F;
   // Reset values and error codes
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [7:0] CME_NONE = 8'h00;
   localparam logic [7:0] CME_ILLEGAL_SET = 8'h04;
   // Break timing: one character frame, 10 bits at 9600 baud
   localparam int CLK_PERIOD_NS = 4;
   localparam int CHAR_FRAME_NS = 1041667;
   localparam int BREAK_CYCLES_DEF = (CHAR_FRAME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BRK_W = 20;

   typedef enum logic [3:0] {
      OP_NONE, OP_STB_Q, OP_SRQ_SET, OP_SRQ_Q, OP_STD_Q, OP_STDM_SET, OP_STDM_Q,
      OP_PEF_Q, OP_PEM_SET, OP_PEM_Q, OP_CLS, OP_OPC, OP_IDN_SET, OP_CERR_Q
   } hsr_op_e;

   typedef struct packed {
      hsr_op_e op;
      logic idx_en;
      logic [2:0] idx;
      logic [7:0] data;
   } hsr_cmd_s;

   typedef struct packed {
      logic in_ovf;
      logic queue_ovf;
      logic exec_err;
      logic parse_err;
      logic [7:0] parse_code;
   } hsr_evt_s;

   typedef struct packed {
      logic [7:0] srq_mask;
      logic [7:0] std_flags;
      logic [7:0] std_mask;
      logic [7:0] port_flags;
      logic [7:0] port_mask;
      logic [7:0] cme_code;
      logic [NUM_PORTS-1:0] brk_seen;
      logic [NUM_PORTS-1:0][BRK_W-1:0] brk_cnt;
      logic rsp_valid;
      logic [7:0] rsp_data;
      logic rqs;
   } hsr_state_s;
endpackage

// File: tb/hsr_port_model.sv
// Optical port instruments signalling service requests by serial break
`timescale 1ns/1ps
module hsr_port_model import hsr_pkg::*; (
   input wire logic clock, // Bench clock
   output logic [NUM_PORTS-1:0] port_rx // Receive lines, 1 = mark
);
   initial port_rx = '1;
   // Space on one line for n edges, then back to mark
   task automatic send_break(input int p, input int n);
      @(posedge clock);
      port_rx[p] <= 1'b0;
      repeat (n) @(posedge clock);
      port_rx[p] <= 1'b1;
   endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the status reporting block
`timescale 1ns/1ps
module testbench import hsr_pkg::*;;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   hsr_cmd_s cmd = '0;
   hsr_evt_s evt = '0;
   logic [NUM_PORTS-1:0] port_rx;
   logic rsp_valid;
   logic rqs;
   logic [7:0] rsp_data;
   int n_errors = 0;
   int num_checks = 0;
   hsr_op_e qs[6] = '{OP_STB_Q, OP_SRQ_Q, OP_STD_Q, OP_STDM_Q, OP_PEF_Q, OP_PEM_Q};

   always #2 clock = ~clock;

   hsr_status #(.BREAK_CYCLES(8)) dut (.clock(clock), .rstn(rstn), .cmd(cmd), .evt(evt),
      .port_rx(port_rx), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rqs(rqs));
   hsr_port_model ports (.clock(clock), .port_rx(port_rx));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Command held for one edge; returns just after the taking edge
   task automatic issue(input hsr_op_e op, input logic ie, input logic [2:0] ix,
         input logic [7:0] d);
      @(posedge clock);
      cmd <= '{op, ie, ix, d};
      @(posedge clock);
      cmd <= '0;
      #1;
   endtask

   task automatic query(input hsr_op_e op, input logic ie, input logic [2:0] ix,
         input logic [7:0] exp);
      issue(op, ie, ix, 8'h00);
      check("rsp_valid", {7'h00, rsp_valid}, 8'h01);
      check(op.name(), rsp_data, exp);
   endtask

   task automatic pulse(input hsr_evt_s e);
      @(posedge clock);
      evt <= e;
      @(posedge clock);
      evt <= '0;
   endtask

   task automatic check_rqs(input logic exp);
      check("rqs", {7'h00, rqs}, {7'h00, exp});
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Whole sequence needs well under 1000 cycles
   initial begin
      #20000;
      n_errors++;
      test_done();
   end

   initial begin
      repeat (20) @(posedge clock);
      rstn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         query(qs[i], 1'b0, 3'd0, 8'h00);
      end
      check_rqs(1'b0);
      $display("test reset values done");

      issue(OP_SRQ_SET, 1'b0, 3'd0, 8'hFF);
      query(OP_SRQ_Q, 1'b0, 3'd0, 8'hBF);
      $display("test service mask done");

      pulse('{1'b1, 1'b1, 1'b1, 1'b1, 8'h03});
      issue(OP_OPC, 1'b0, 3'd0, 8'h00);
      query(OP_STD_Q, 1'b1, 3'd3, 8'h01);
      query(OP_STD_Q, 1'b0, 3'd0, 8'h33);
      query(OP_STD_Q, 1'b0, 3'd0, 8'h00);
      query(OP_CERR_Q, 1'b0, 3'd0, 8'h03);
      issue(OP_IDN_SET, 1'b0, 3'd0, 8'h00);
      query(OP_CERR_Q, 1'b0, 3'd0, 8'h04);
      check_rqs(1'b0);
      issue(OP_STDM_SET, 1'b0, 3'd0, 8'h20);
      check_rqs(1'b1);
      query(OP_STB_Q, 1'b0, 3'd0, 8'h60);
      issue(OP_CLS, 1'b0, 3'd0, 8'h00);
      check_rqs(1'b0);
      query(OP_STD_Q, 1'b0, 3'd0, 8'h00);
      $display("test standard events done");

      issue(OP_PEM_SET, 1'b1, 3'd2, 8'h01);
      query(OP_PEM_Q, 1'b0, 3'd0, 8'h04);
      ports.send_break(1, 12);
      query(OP_STB_Q, 1'b0, 3'd0, 8'h00);
      ports.send_break(2, 12);
      query(OP_STB_Q, 1'b0, 3'd0, 8'h41);
      check_rqs(1'b1);
      query(OP_PEF_Q, 1'b0, 3'd0, 8'h06);
      query(OP_PEF_Q, 1'b0, 3'd0, 8'h00);
      check_rqs(1'b0);
      ports.send_break(0, 12);
      issue(OP_CLS, 1'b0, 3'd0, 8'h00);
      query(OP_PEF_Q, 1'b0, 3'd0, 8'h00);
      ports.send_break(3, 5);
      query(OP_PEF_Q, 1'b0, 3'd0, 8'h00);
      $display("test port events done");
      test_done();
   end
endmodule
